// file: rtl/pvr_params.svh
/*
  constants for the process-value input range and square root block.
  assumes it is included by bare name from the design file.
*/
`ifndef PVR_PARAMS_SVH
`define PVR_PARAMS_SVH
// ==========================================================
// range numbers
`define PVR_TC_FIRST 7'h01
`define PVR_TC_LAST 7'h19
`define PVR_TC_BTYPE 7'h11
`define PVR_RTD_FIRST 7'h29
`define PVR_RTD_LAST 7'h44
// resistance thermometer ranges that allow one fractional digit
`define PVR_RTD_DP1_FIRST 7'h33
`define PVR_RTD_DP1_LAST 7'h36
`define PVR_RTD_DP1_LOW2 7'h3F
`define PVR_RTD_DP1_HIGH2 7'h40
`define PVR_DC_FIRST 7'h54
`define PVR_DC_LAST 7'h5A
`define PVR_DC_GAP 7'h55
// ==========================================================
// defaults and limits, display counts and tenths of a percent
`define PVR_RANGE_RST 7'h58
`define PVR_SCALE_LO_RST 16'sh0000
`define PVR_SCALE_HI_RST 16'sh03E8
`define PVR_SCALE_MIN 16'shF831
`define PVR_SCALE_MAX 16'sh270F
`define PVR_PCT_FULL 16'sh03E8
`define PVR_DROP_MAX 11'h3E8
`define PVR_DP_MAX_TEMP 2'h1
`define PVR_DP_MAX_DC 2'h3
// b-type low indication limit, degrees; firmware version in hundredths
`define PVR_BLOW_NEW 16'sh0014
`define PVR_BLOW_OLD 16'shFF4C
`define PVR_FW_BLOW_VER 16'h00CC
`endif

// file: rtl/pvr_pkg.sv
/*
  types for the process-value input range block.
  assumes nothing beyond the constants header.
*/
package pvr_pkg;
  // ==========================================================
  // input class decoded from the range number
  typedef enum logic [3:0] {
    PVR_CLS_NONE = 4'b0001,
    PVR_CLS_TC = 4'b0010,
    PVR_CLS_RTD = 4'b0100,
    PVR_CLS_DC = 4'b1000
  } pvr_class_t;
  // square root stage sequencer
  typedef enum logic [2:0] {
    PVR_SQ_IDLE = 3'b001,
    PVR_SQ_RUN = 3'b010,
    PVR_SQ_DONE = 3'b100
  } pvr_sq_state_t;
endpackage

// file: rtl/pvr_range_sqrt.sv
/*
  process-value input range setup and square root extraction stage.
  assumes settings arrive as one-cycle write strobes from synchronous
  host logic, and sample_tick is a one-cycle enable on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pvr_params.svh"
module pvr_range_sqrt (
  input wire logic clk,
  input wire logic rst,
  input wire logic [6:0] range_number_wdata,
  input wire logic range_number_we,
  input wire logic temperature_unit_select_wdata,
  input wire logic temperature_unit_select_we,
  input wire logic cold_junction_select_wdata,
  input wire logic cold_junction_select_we,
  input wire logic [1:0] decimal_position_wdata,
  input wire logic decimal_position_we,
  input wire logic signed [15:0] scale_low_limit_wdata,
  input wire logic scale_low_limit_we,
  input wire logic signed [15:0] scale_high_limit_wdata,
  input wire logic scale_high_limit_we,
  input wire logic [10:0] sqrt_dropout_wdata,
  input wire logic sqrt_dropout_we,
  input wire logic [15:0] firmware_version_info,
  input wire logic sample_tick,
  input wire logic signed [15:0] stage_input_pct,
  output logic [6:0] range_number,
  output pvr_pkg::pvr_class_t input_class,
  output logic temperature_unit_select,
  output logic cold_junction_select,
  output logic [1:0] decimal_position,
  output logic signed [15:0] scale_low_limit,
  output logic signed [15:0] scale_high_limit,
  output logic signed [15:0] range_low_indication,
  output logic [10:0] sqrt_dropout,
  output logic decimal_shift_valid,
  output logic signed [2:0] decimal_shift,
  output logic signed [15:0] stage_output_pct,
  output logic stage_output_valid
);
  import pvr_pkg::*;

  // ==========================================================
  // range decode
  // a wrong number cannot switch class; unknown numbers are refused outright
  function automatic pvr_class_t class_of(input logic [6:0] n);
    if (n >= `PVR_TC_FIRST && n <= `PVR_TC_LAST) begin
      class_of = PVR_CLS_TC;
    end else if (n >= `PVR_RTD_FIRST && n <= `PVR_RTD_LAST) begin
      class_of = PVR_CLS_RTD;
    end else if (n >= `PVR_DC_FIRST && n <= `PVR_DC_LAST && n != `PVR_DC_GAP) begin
      class_of = PVR_CLS_DC;
    end else begin
      class_of = PVR_CLS_NONE;
    end
  endfunction

  // decimal ceiling for a range; dc allows three digits, and of the temperature ranges only rtd codes in the table allow one
  function automatic logic [1:0] dp_max_of(input logic [6:0] n);
    if (class_of(n) == PVR_CLS_DC) begin
      dp_max_of = `PVR_DP_MAX_DC;
    end else if ((n >= `PVR_RTD_DP1_FIRST && n <= `PVR_RTD_DP1_LAST)
      || n == `PVR_RTD_DP1_LOW2 || n == `PVR_RTD_DP1_HIGH2) begin
      dp_max_of = `PVR_DP_MAX_TEMP;
    end else begin
      dp_max_of = 2'h0;
    end
  endfunction

  pvr_class_t wr_class;
  logic range_ok;
  logic is_dc;
  logic is_temp;
  logic [1:0] dp_max;
  logic [1:0] wr_dp_max;
  logic dp_ok;
  logic lo_ok;
  logic hi_ok;
  logic drop_ok;
  logic [1:0] next_decimal;

  assign wr_class = class_of(range_number_wdata);
  assign range_ok = range_number_we && wr_class != PVR_CLS_NONE;
  assign is_dc = input_class == PVR_CLS_DC;
  assign is_temp = input_class == PVR_CLS_TC || input_class == PVR_CLS_RTD;
  assign dp_max = dp_max_of(range_number);
  assign wr_dp_max = dp_max_of(range_number_wdata);
  assign dp_ok = decimal_position_we && decimal_position_wdata <= dp_max;
  assign lo_ok = scale_low_limit_we && is_dc && scale_low_limit_wdata >= `PVR_SCALE_MIN
    && scale_low_limit_wdata <= `PVR_SCALE_MAX;
  assign hi_ok = scale_high_limit_we && is_dc && scale_high_limit_wdata >= `PVR_SCALE_MIN
    && scale_high_limit_wdata <= `PVR_SCALE_MAX;
  assign drop_ok = sqrt_dropout_we && is_dc && sqrt_dropout_wdata <= `PVR_DROP_MAX;
  // range write: dc keeps the digit, temperature ranges take the table value
  assign next_decimal = range_ok ? ((wr_class == PVR_CLS_DC) ? decimal_position
    : ((wr_dp_max != 2'h0) ? 2'h1 : 2'h0)) : decimal_position_wdata;

  // ==========================================================
  // setting registers
  always_ff @(posedge clk) begin
    if (rst) begin
      range_number <= `PVR_RANGE_RST;
      input_class <= PVR_CLS_DC;
      decimal_position <= 2'h0;
    end else if (range_ok || dp_ok) begin
      if (range_ok) begin
        range_number <= range_number_wdata;
        input_class <= wr_class;
      end
      decimal_position <= next_decimal;
    end
  end

  // scale limits; a range write to dc restores defaults and beats a limit write
  always_ff @(posedge clk) begin
    if (rst || (range_ok && wr_class == PVR_CLS_DC)) begin
      scale_low_limit <= `PVR_SCALE_LO_RST;
      scale_high_limit <= `PVR_SCALE_HI_RST;
    end else begin
      if (lo_ok) begin
        scale_low_limit <= scale_low_limit_wdata;
      end
      if (hi_ok) begin
        scale_high_limit <= scale_high_limit_wdata;
      end
    end
  end

  // unit, junction and dropout; each refused outside its input class
  always_ff @(posedge clk) begin
    if (rst) begin
      temperature_unit_select <= 1'b0;
      cold_junction_select <= 1'b0;
      sqrt_dropout <= 11'h000;
    end else begin
      if (temperature_unit_select_we && is_temp) begin
        temperature_unit_select <= temperature_unit_select_wdata;
      end
      if (cold_junction_select_we && input_class == PVR_CLS_TC) begin
        cold_junction_select <= cold_junction_select_wdata;
      end
      if (drop_ok) begin
        sqrt_dropout <= sqrt_dropout_wdata;
      end
    end
  end

  // ==========================================================
  // decimal shift notice for dependent settings owned elsewhere
  always_ff @(posedge clk) begin
    if (rst) begin
      decimal_shift_valid <= 1'b0;
      decimal_shift <= 3'sh0;
    end else begin
      decimal_shift_valid <= (range_ok || dp_ok) && next_decimal != decimal_position;
      decimal_shift <= $signed({1'b0, next_decimal}) - $signed({1'b0, decimal_position});
    end
  end

  // b-type low indication follows the firmware generation; a level, so no reset needed
  always_ff @(posedge clk) begin
    range_low_indication <= (firmware_version_info < `PVR_FW_BLOW_VER)
      ? `PVR_BLOW_OLD : `PVR_BLOW_NEW;
  end

  // ==========================================================
  // square root stage: bit-serial root of in*1000 gives tenths directly
  pvr_sq_state_t state;
  logic [19:0] radicand;
  logic [10:0] root;
  logic [21:0] remain;
  logic [3:0] step;
  logic use_root;
  logic drop_zero;
  logic [21:0] trial;
  logic [21:0] shifted;

  // classify the sample; dropout 0 or a non-dc input passes straight through
  assign use_root = is_dc && sqrt_dropout != 11'h000 && stage_input_pct > 16'sh0000
    && stage_input_pct < `PVR_PCT_FULL && stage_input_pct >= $signed({5'h00, sqrt_dropout});
  assign drop_zero = is_dc && sqrt_dropout != 11'h000 && stage_input_pct > 16'sh0000
    && stage_input_pct < $signed({5'h00, sqrt_dropout});
  assign shifted = {remain[19:0], radicand[19:18]};
  assign trial = {9'h000, root, 2'b01};

  // ten two-bit iterations, so a tick must come no faster than every 12 cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= PVR_SQ_IDLE;
      radicand <= 20'h0_0000;
      root <= 11'h000;
      remain <= 22'h00_0000;
      step <= 4'h0;
    end else begin
      case (state)
        PVR_SQ_IDLE: begin
          if (sample_tick && use_root) begin
            radicand <= {10'h000, stage_input_pct[9:0]} * 20'h0_03E8;
            root <= 11'h000;
            remain <= 22'h00_0000;
            step <= 4'h0;
            state <= PVR_SQ_RUN;
          end
        end
        PVR_SQ_RUN: begin
          radicand <= {radicand[17:0], 2'b00};
          if (shifted >= trial) begin
            remain <= shifted - trial;
            root <= {root[9:0], 1'b1};
          end else begin
            remain <= shifted;
            root <= {root[9:0], 1'b0};
          end
          step <= step + 4'h1;
          if (step == 4'h9) begin
            state <= PVR_SQ_DONE;
          end
        end
        PVR_SQ_DONE: begin
          state <= PVR_SQ_IDLE;
        end
        default: begin
          state <= PVR_SQ_IDLE;
        end
      endcase
    end
  end

  // output register: pass, zero, or root, one valid pulse per tick taken in idle
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_output_pct <= 16'sh0000;
      stage_output_valid <= 1'b0;
    end else if (state == PVR_SQ_DONE) begin
      stage_output_pct <= $signed({5'h00, root});
      stage_output_valid <= 1'b1;
    end else if (state == PVR_SQ_IDLE && sample_tick && !use_root) begin
      stage_output_pct <= drop_zero ? 16'sh0000 : stage_input_pct;
      stage_output_valid <= 1'b1;
    end else begin
      stage_output_valid <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  // a root request taken in idle, then its result pulse twelve edges on
  sequence s_root_start;
    sample_tick && state == PVR_SQ_IDLE && use_root;
  endsequence
  sequence s_root_result;
    ##12 stage_output_valid;
  endsequence
  a_range_class_set: assert property (@(posedge clk) disable iff (rst)
    range_ok |=> input_class != PVR_CLS_NONE && range_number == $past(range_number_wdata))
    else $error("range write did not take");
  a_rtd_decimal_init: assert property (@(posedge clk) disable iff (rst)
    range_ok && wr_class == PVR_CLS_RTD |=> decimal_position == $past(wr_dp_max))
    else $error("rtd decimal initial wrong");
  a_dc_decimal_kept: assert property (@(posedge clk) disable iff (rst)
    range_ok && wr_class == PVR_CLS_DC |=> $stable(decimal_position))
    else $error("dc range changed decimal");
  a_dc_scale_default: assert property (@(posedge clk) disable iff (rst)
    range_ok && wr_class == PVR_CLS_DC |=> scale_low_limit == `PVR_SCALE_LO_RST
    && scale_high_limit == `PVR_SCALE_HI_RST)
    else $error("scale defaults not restored");
  a_scale_span: assert property (@(posedge clk) disable iff (rst)
    scale_low_limit >= `PVR_SCALE_MIN && scale_low_limit <= `PVR_SCALE_MAX
    && scale_high_limit >= `PVR_SCALE_MIN && scale_high_limit <= `PVR_SCALE_MAX)
    else $error("scale limit out of span");
  a_unit_class: assert property (@(posedge clk) disable iff (rst)
    temperature_unit_select_we && !is_temp |=> $stable(temperature_unit_select))
    else $error("unit written outside temperature class");
  a_junction_class: assert property (@(posedge clk) disable iff (rst)
    cold_junction_select_we && input_class != PVR_CLS_TC |=> $stable(cold_junction_select))
    else $error("junction written outside thermocouple class");
  a_dropout_zero: assert property (@(posedge clk) disable iff (rst)
    sample_tick && state == PVR_SQ_IDLE && drop_zero |=> stage_output_valid
    && stage_output_pct == 16'sh0000)
    else $error("dropout did not force zero");
  a_pass_through: assert property (@(posedge clk) disable iff (rst)
    sample_tick && state == PVR_SQ_IDLE && !use_root && !drop_zero |=> stage_output_valid
    && stage_output_pct == $past(stage_input_pct))
    else $error("pass-through value wrong");
  a_root_latency: assert property (@(posedge clk) disable iff (rst)
    s_root_start |-> s_root_result)
    else $error("root result late");
  a_shift_pulse: assert property (@(posedge clk) disable iff (rst)
    decimal_shift_valid |-> $signed({1'b0, decimal_position})
    == $signed({1'b0, $past(decimal_position)}) + decimal_shift)
    else $error("decimal shift does not match change");
endmodule
`default_nettype wire

// file: tb/pvr_host_model.sv
/*
  host side model: writes setup settings and feeds process samples.
  assumes one clock shared with the block; strobes last one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pvr_host_model (
  input wire logic clk,
  output logic [6:0] range_number_wdata,
  output logic range_number_we,
  output logic temperature_unit_select_wdata,
  output logic temperature_unit_select_we,
  output logic cold_junction_select_wdata,
  output logic cold_junction_select_we,
  output logic [1:0] decimal_position_wdata,
  output logic decimal_position_we,
  output logic signed [15:0] scale_low_limit_wdata,
  output logic scale_low_limit_we,
  output logic signed [15:0] scale_high_limit_wdata,
  output logic scale_high_limit_we,
  output logic [10:0] sqrt_dropout_wdata,
  output logic sqrt_dropout_we,
  output var logic [15:0] firmware_version_info,
  output var logic sample_tick,
  output var logic signed [15:0] stage_input_pct
);
  // ==========================================================
  // shared write bus
  logic [15:0] bus_v = 16'h5a5a;
  logic [6:0] we_v = 7'h00;
  // one bus fans out to every setting; it is inverted when idle so stale data never looks valid
  assign range_number_wdata = bus_v[6:0];
  assign temperature_unit_select_wdata = bus_v[0];
  assign cold_junction_select_wdata = bus_v[0];
  assign decimal_position_wdata = bus_v[1:0];
  assign scale_low_limit_wdata = bus_v;
  assign scale_high_limit_wdata = bus_v;
  assign sqrt_dropout_wdata = bus_v[10:0];
  assign {sqrt_dropout_we, scale_high_limit_we, scale_low_limit_we} = we_v[6:4];
  assign {decimal_position_we, cold_junction_select_we} = we_v[3:2];
  assign {temperature_unit_select_we, range_number_we} = we_v[1:0];
  // idle levels at time zero
  initial begin
    firmware_version_info = 16'h00cc;
    sample_tick = 1'h0;
    stage_input_pct = 16'h0000;
  end
  // one-cycle strobe on the selected setting: 0 range, 1 unit, 2 junction, 3 decimal,
  // 4 low, 5 high, 6 dropout
  task automatic wr(input int sel, input logic [15:0] v);
    @(posedge clk);
    bus_v <= v;
    we_v <= 7'h01 << sel;
    @(posedge clk);
    bus_v <= ~v;
    we_v <= 7'h00;
  endtask
  // one sample with its tick; the sample line is scrambled afterwards
  task automatic tick(input logic [15:0] v);
    @(posedge clk);
    stage_input_pct <= v;
    sample_tick <= 1'h1;
    @(posedge clk);
    stage_input_pct <= ~v;
    sample_tick <= 1'h0;
  endtask
  // firmware generation is a level: changed on one edge, taken at the next
  task automatic fw_set(input logic [15:0] v);
    @(posedge clk);
    firmware_version_info <= v;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
/*
  self-checking bench for the range setup and square root stage.
  assumes the host model drives every write strobe and sample.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pvr_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [6:0] range_number_wdata, range_number;
  logic [1:0] decimal_position_wdata, decimal_position;
  logic [10:0] sqrt_dropout_wdata, sqrt_dropout;
  logic [15:0] firmware_version_info;
  logic signed [15:0] scale_low_limit_wdata, scale_high_limit_wdata, stage_input_pct;
  logic signed [15:0] scale_low_limit, scale_high_limit, range_low_indication, stage_output_pct;
  logic signed [2:0] decimal_shift;
  pvr_class_t input_class;
  logic range_number_we, temperature_unit_select_wdata, temperature_unit_select_we;
  logic cold_junction_select_wdata, cold_junction_select_we, decimal_position_we;
  logic scale_low_limit_we, scale_high_limit_we, sqrt_dropout_we, sample_tick;
  logic temperature_unit_select, cold_junction_select, decimal_shift_valid, stage_output_valid;
  logic [15:0] dc_codes [6] = '{16'h0054, 16'h0056, 16'h0057, 16'h0058, 16'h0059, 16'h005a};
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  // ==========================================================
  // instances
  pvr_host_model host_u (.clk, .range_number_wdata, .range_number_we,
    .temperature_unit_select_wdata, .temperature_unit_select_we, .cold_junction_select_wdata,
    .cold_junction_select_we, .decimal_position_wdata, .decimal_position_we,
    .scale_low_limit_wdata, .scale_low_limit_we, .scale_high_limit_wdata, .scale_high_limit_we,
    .sqrt_dropout_wdata, .sqrt_dropout_we, .firmware_version_info, .sample_tick,
    .stage_input_pct);
  pvr_range_sqrt dut_u (.clk, .rst, .range_number_wdata, .range_number_we,
    .temperature_unit_select_wdata, .temperature_unit_select_we, .cold_junction_select_wdata,
    .cold_junction_select_we, .decimal_position_wdata, .decimal_position_we,
    .scale_low_limit_wdata, .scale_low_limit_we, .scale_high_limit_wdata, .scale_high_limit_we,
    .sqrt_dropout_wdata, .sqrt_dropout_we, .firmware_version_info, .sample_tick,
    .stage_input_pct, .range_number, .input_class, .temperature_unit_select,
    .cold_junction_select, .decimal_position, .scale_low_limit, .scale_high_limit,
    .range_low_indication, .sqrt_dropout, .decimal_shift_valid, .decimal_shift,
    .stage_output_pct, .stage_output_valid);
  // ==========================================================
  // clock and hang guard; the sequence needs well under a thousand cycles
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end
  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic done(input string t);
    $display("test %s done", t);
  endtask
  // write, then let the taking edge land before anything is sampled
  task automatic w(input int sel, input logic [15:0] v);
    host_u.wr(sel, v);
    #1;
  endtask
  // one sample through the root stage; waits bounded, then spaces ticks past the busy window
  task automatic sq(input logic [15:0] v, input logic [15:0] exp, input int lat);
    int n = 0;
    host_u.tick(v);
    #1;
    while (stage_output_valid !== 1'h1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("stage_output_valid", stage_output_valid, 16'h0001);
    check("stage_output_pct", stage_output_pct, exp);
    check("result_latency", 16'(n), 16'(lat));
    @(posedge clk);
    #1;
    check("stage_output_valid", stage_output_valid, 16'h0000);
    repeat (13) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    #1;
    check("range_number", range_number, 16'h0058);
    check("input_class", input_class, PVR_CLS_DC);
    check("temperature_unit_select", temperature_unit_select, 16'h0000);
    check("cold_junction_select", cold_junction_select, 16'h0000);
    check("decimal_position", decimal_position, 16'h0000);
    check("scale_low_limit", scale_low_limit, 16'h0000);
    check("scale_high_limit", scale_high_limit, 16'h03e8);
    check("sqrt_dropout", sqrt_dropout, 16'h0000);
    check("range_low_indication", range_low_indication, 16'h0014);
    host_u.fw_set(16'h00cb);
    #1;
    check("range_low_indication", range_low_indication, 16'hff4c);
    host_u.fw_set(16'h00cc);
    #1;
    check("range_low_indication", range_low_indication, 16'h0014);
    done("reset");
    // dc: decimal, scale span edges, then every dc code
    w(3, 16'h0003);
    check("decimal_position", decimal_position, 16'h0003);
    check("decimal_shift_valid", decimal_shift_valid, 16'h0001);
    check("decimal_shift", decimal_shift, 16'h0003);
    w(4, 16'hf830);
    check("scale_low_limit", scale_low_limit, 16'h0000);
    w(4, 16'hf831);
    check("scale_low_limit", scale_low_limit, 16'hf831);
    w(5, 16'h2710);
    check("scale_high_limit", scale_high_limit, 16'h03e8);
    w(5, 16'h270f);
    check("scale_high_limit", scale_high_limit, 16'h270f);
    foreach (dc_codes[i]) begin
      w(0, dc_codes[i]);
      check("range_number", range_number, dc_codes[i]);
      check("decimal_position", decimal_position, 16'h0003);
      check("scale_low_limit", scale_low_limit, 16'h0000);
      check("scale_high_limit", scale_high_limit, 16'h03e8);
    end
    w(0, 16'h0055);
    check("range_number", range_number, 16'h005a);
    w(1, 16'h0001);
    check("temperature_unit_select", temperature_unit_select, 16'h0000);
    done("dc setup");
    // root stage: disabled, refused dropout, then every input band
    sq(16'h01f4, 16'h01f4, 0);
    w(6, 16'h03e9);
    check("sqrt_dropout", sqrt_dropout, 16'h0000);
    w(6, 16'h0064);
    check("sqrt_dropout", sqrt_dropout, 16'h0064);
    sq(16'h0032, 16'h0000, 0);
    sq(16'h0064, 16'h013c, 11);
    sq(16'h00fa, 16'h01f4, 11);
    sq(16'h03e7, 16'h03e7, 11);
    sq(16'h03e8, 16'h03e8, 0);
    sq(16'h0000, 16'h0000, 0);
    sq(16'hfffb, 16'hfffb, 0);
    done("square root");
    // resistance thermometer ranges
    w(0, 16'h0034);
    check("input_class", input_class, PVR_CLS_RTD);
    check("decimal_position", decimal_position, 16'h0001);
    w(0, 16'h0043);
    check("decimal_position", decimal_position, 16'h0000);
    w(0, 16'h003f);
    check("decimal_position", decimal_position, 16'h0001);
    w(3, 16'h0002);
    check("decimal_position", decimal_position, 16'h0001);
    check("decimal_shift_valid", decimal_shift_valid, 16'h0000);
    w(3, 16'h0000);
    check("decimal_shift", decimal_shift, 16'hffff);
    w(1, 16'h0001);
    check("temperature_unit_select", temperature_unit_select, 16'h0001);
    w(2, 16'h0001);
    check("cold_junction_select", cold_junction_select, 16'h0000);
    w(4, 16'h0005);
    check("scale_low_limit", scale_low_limit, 16'h0000);
    w(6, 16'h0001);
    check("sqrt_dropout", sqrt_dropout, 16'h0064);
    sq(16'h0032, 16'h0032, 0);
    done("rtd");
    // thermocouple ranges
    w(0, 16'h0011);
    check("input_class", input_class, PVR_CLS_TC);
    w(3, 16'h0001);
    check("decimal_position", decimal_position, 16'h0000);
    w(2, 16'h0001);
    check("cold_junction_select", cold_junction_select, 16'h0001);
    w(0, 16'h001a);
    check("range_number", range_number, 16'h0011);
    done("thermocouple");
    // mid-run reset must put back every setting changed above
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    #1;
    check("range_number", range_number, 16'h0058);
    check("input_class", input_class, PVR_CLS_DC);
    check("temperature_unit_select", temperature_unit_select, 16'h0000);
    check("cold_junction_select", cold_junction_select, 16'h0000);
    check("decimal_position", decimal_position, 16'h0000);
    check("sqrt_dropout", sqrt_dropout, 16'h0000);
    done("second reset");
    wrap_up();
  end
endmodule
`default_nettype wire
